// ---- common/pil_pkg.sv ----
// Purpose : Constants shared by the peripheral interrupt logic.
// Assumes : APB byte addresses, one 32-bit word per register.
// Notes   : Offsets are relative to the slave's own base address.
package pil_pkg;

  // ==========================================================
  // Processor vectors
  localparam logic [31:0] PIL_RESET_VEC  = 32'h0000_0000;
  localparam logic [31:0] PIL_EXCEPT_VEC = 32'h0000_0020;

  // ==========================================================
  // Interrupt line numbers
  localparam int PIL_IRQ_TIMER0 = 0;
  localparam int PIL_IRQ_KEYS   = 1;
  localparam int PIL_IRQ_TIMER1 = 2;
  localparam int PIL_IRQ_SERIAL = 8;
  localparam int PIL_IRQ_EXPAN  = 11;
  localparam int PIL_IRQ_BOARD  = 13;

  // ==========================================================
  // Parallel port layout: port n sits at n * PIL_PORT_STRIDE
  localparam logic [11:0] PIL_PORT_STRIDE = 12'h010;
  localparam logic [3:0]  PIL_PP_DATA     = 4'h0;
  localparam logic [3:0]  PIL_PP_MASK     = 4'h8;
  localparam logic [3:0]  PIL_PP_EDGE     = 4'hC;

  // ==========================================================
  // Serial port, timers and pending vector
  localparam logic [11:0] PIL_SER_DATA  = 12'h030;
  localparam logic [11:0] PIL_SER_CTRL  = 12'h034;
  localparam logic [11:0] PIL_TMR_BASE  = 12'h040;
  localparam logic [11:0] PIL_TMR_STRD  = 12'h010;
  localparam logic [3:0]  PIL_TMR_STAT  = 4'h0;
  localparam logic [3:0]  PIL_TMR_CTRL  = 4'h4;
  localparam logic [11:0] PIL_PEND      = 12'h060;

  // Field positions
  localparam int PIL_CNT_LSB   = 16;
  localparam int PIL_RXEN_BIT  = 0;
  localparam int PIL_TXEN_BIT  = 1;
  localparam int PIL_RXPND_BIT = 8;
  localparam int PIL_TXPND_BIT = 9;
  localparam int PIL_ZERO_BIT  = 0;
  localparam int PIL_ZEN_BIT   = 0;

  // Threshold for serial buffer interrupts (level must exceed it)
  localparam logic [15:0] PIL_SER_THRESH = 16'h0007;

  // Reset values
  localparam logic [31:0] PIL_RST_WORD = 32'h0000_0000;

endpackage

// ---- hw/pil_top.sv ----
// Purpose : Interrupt sources and routing for a soft-processor system.
// Assumes : One clock pclk (100 MHz), async active-low presetn, APB slave.
// Notes   : Parallel inputs come from pins; serial levels and timer
//           zero pulses come from logic on pclk. Every output comes
//           from a flip-flop; request lines lag their source by one
//           clock.
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// - Processor starts fetching at address zero
// - Exceptions and interrupts share vector 0x20
// - Pending line vector readable by handler
// - Timer one on line 0, two on 2
// - Pushbutton port drives line 1
// - Serial line 8, expansion 11, board 13
// - Mask at Base+8 enables per-bit interrupts
// - Edge latch at Base+C catches rises
// - Any latch write clears bits and request
// - Key press sets latch, interrupts if enabled
// - Data reports fill, control reports free
// - Separate receive and transmit interrupt enables
// - Interrupt while count greater than seven
// - Pending bits follow levels across threshold
// - Zero flag set when count reaches zero
// - Zero enable sends request on flag
// - Any status write clears timer interrupt
// - Free count in control bits 31..16
module pil_top #(
  parameter int PORT_W = 32
) (
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output var  logic [31:0]       prdata,
  output var  logic              pready,
  output var  logic              pslverr,
  // Parallel port pins: keys, expansion header, board header
  input  wire logic [PORT_W-1:0] key_in,
  input  wire logic [PORT_W-1:0] expan_in,
  input  wire logic [PORT_W-1:0] board_in,
  // Serial buffer levels and strobes
  input  wire logic [15:0]       rx_fill_count,
  input  wire logic [15:0]       tx_free_count,
  input  wire logic [7:0]        rx_char,
  output var  logic              rx_pop,
  output var  logic              tx_push,
  output var  logic [7:0]        tx_char,
  // Timer zero events
  input  wire logic              timer0_zero,
  input  wire logic              timer1_zero,
  // Processor side
  output var  logic [31:0]       reset_vector,
  output var  logic [31:0]       exception_vector,
  output var  logic [31:0]       irq
);

  // ==========================================================
  // APB handshake
  logic acc;
  logic done;
  logic wr;
  logic rd;
  // A transfer completes at the edge where pready is seen high
  assign acc  = psel & penable;
  assign done = acc & pready;
  assign wr   = done & pwrite;
  assign rd   = done & ~pwrite;

  // One wait state so read data can come from a flip-flop. Every
  // transfer takes exactly that one wait state, so the handshake
  // never depends on which register is addressed.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= acc & ~pready;
    end
  end

  // Address match helper
  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a[11:2] == off[11:2]);
  endfunction

  // Port register address; the ports sit one stride apart
  function automatic logic [11:0] pp_addr(input int n, input logic [3:0] off);
    pp_addr = 12'(n * pil_pkg::PIL_PORT_STRIDE) | {8'h00, off};
  endfunction

  // Timer register address; both timers share one layout
  function automatic logic [11:0] tmr_addr(input int n, input logic [3:0] off);
    tmr_addr = pil_pkg::PIL_TMR_BASE + 12'(n * pil_pkg::PIL_TMR_STRD) + {8'h00, off};
  endfunction

  // ==========================================================
  // Parallel ports: 0 keys, 1 expansion, 2 board header
  logic [PORT_W-1:0] pin_raw [3];
  logic [PORT_W-1:0] sync1   [3];
  logic [PORT_W-1:0] sync2   [3];
  logic [PORT_W-1:0] sync3   [3];
  logic [PORT_W-1:0] level   [3];
  logic [PORT_W-1:0] next_level [3];
  logic [PORT_W-1:0] mask    [3];
  logic [PORT_W-1:0] latch   [3];
  logic [2:0]        pp_irq;
  logic [2:0]        mask_wr;
  logic [2:0]        edge_wr;

  assign pin_raw[0] = key_in;
  assign pin_raw[1] = expan_in;
  assign pin_raw[2] = board_in;

  for (genvar p = 0; p < 3; p++) begin : g_port
    // Decode writes to mask and latch
    assign mask_wr[p] = wr & hit(paddr, pp_addr(p, pil_pkg::PIL_PP_MASK));
    assign edge_wr[p] = wr & hit(paddr, pp_addr(p, pil_pkg::PIL_PP_EDGE));

    // A change counts once the second and third stages agree
    assign next_level[p] = (sync2[p] & ~(sync2[p] ^ sync3[p]))
                         | (level[p] & (sync2[p] ^ sync3[p]));

    // Pin synchroniser, first stage read only by the second. From pin
    // to request line: three sampling stages, one edge for the filter
    // to move the level and set the latch on the same edge, then the registered line. A
    // pulse shorter than two clocks may be missed; the filter trades
    // that for never counting a half-settled sample.
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        sync1[p] <= '0;
        sync2[p] <= '0;
        sync3[p] <= '0;
        level[p] <= '0;
      end else begin
        sync1[p] <= pin_raw[p];
        sync2[p] <= sync1[p];
        sync3[p] <= sync2[p];
        level[p] <= next_level[p];
      end
    end

    // Interrupt enable mask
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        mask[p] <= '0;
      end else if (mask_wr[p]) begin
        mask[p] <= pwdata[PORT_W-1:0];
      end
    end

    // Edge latch: a rise landing with the clearing write is kept, so
    // a key pressed while the handler clears the latch is not lost;
    // the handler sees the bit again on its next pass. Reads never
    // clear it, so a polling loop may look as often as it likes.
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        latch[p] <= '0;
      end else begin
        latch[p] <= (edge_wr[p] ? '0 : latch[p])
                  | (next_level[p] & ~level[p]);
      end
    end

    assign pp_irq[p] = |(latch[p] & mask[p]);
  end

  // ==========================================================
  // Serial port interrupts
  logic rx_en;
  logic tx_en;
  logic rx_pend;
  logic tx_pend;
  logic ser_ctrl_wr;

  assign ser_ctrl_wr = wr & hit(paddr, pil_pkg::PIL_SER_CTRL);

  // Enables are the only writable control bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_en <= 1'b0;
      tx_en <= 1'b0;
    end else if (ser_ctrl_wr) begin
      rx_en <= pwdata[pil_pkg::PIL_RXEN_BIT];
      tx_en <= pwdata[pil_pkg::PIL_TXEN_BIT];
    end
  end

  // Levels, not latches: reading or writing data moves them back.
  // A pending bit still up after a read means the buffer still holds
  // more than the threshold, which is intended: the handler loops.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_pend <= 1'b0;
      tx_pend <= 1'b0;
    end else begin
      rx_pend <= rx_en & (rx_fill_count > pil_pkg::PIL_SER_THRESH);
      tx_pend <= tx_en & (tx_free_count > pil_pkg::PIL_SER_THRESH);
    end
  end

  // Buffer strobes, one cycle each, raised after the completing edge
  // so the buffer sees each access once however long software waits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_pop  <= 1'b0;
      tx_push <= 1'b0;
      tx_char <= 8'h00;
    end else begin
      rx_pop  <= rd & hit(paddr, pil_pkg::PIL_SER_DATA);
      tx_push <= wr & hit(paddr, pil_pkg::PIL_SER_DATA);
      if (wr & hit(paddr, pil_pkg::PIL_SER_DATA)) begin
        tx_char <= pwdata[7:0];
      end
    end
  end

  // ==========================================================
  // Interval timer flags
  logic [1:0] zero_ev;
  logic [1:0] zero_flag;
  logic [1:0] zero_en;
  logic [1:0] tmr_irq;

  assign zero_ev = {timer1_zero, timer0_zero};

  for (genvar t = 0; t < 2; t++) begin : g_tmr
    // Set on reaching zero wins over a clearing status write, so a
    // timeout that lands with the clear is never lost; the handler
    // just sees the flag once more and services it again.
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        zero_flag[t] <= 1'b0;
      end else if (zero_ev[t]) begin
        zero_flag[t] <= 1'b1;
      end else if (wr & hit(paddr, tmr_addr(t, pil_pkg::PIL_TMR_STAT))) begin
        zero_flag[t] <= 1'b0;
      end
    end

    // Interrupt enable for the zero flag
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        zero_en[t] <= 1'b0;
      end else if (wr & hit(paddr, tmr_addr(t, pil_pkg::PIL_TMR_CTRL))) begin
        zero_en[t] <= pwdata[pil_pkg::PIL_ZEN_BIT];
      end
    end

    assign tmr_irq[t] = zero_flag[t] & zero_en[t];
  end

  // ==========================================================
  // Line routing
  logic [31:0] next_irq;

  // Each source goes to the bit equal to its line number
  always_comb begin
    next_irq = '0;
    next_irq[pil_pkg::PIL_IRQ_TIMER0] = tmr_irq[0];
    next_irq[pil_pkg::PIL_IRQ_KEYS]   = pp_irq[0];
    next_irq[pil_pkg::PIL_IRQ_TIMER1] = tmr_irq[1];
    next_irq[pil_pkg::PIL_IRQ_SERIAL] = rx_pend | tx_pend;
    next_irq[pil_pkg::PIL_IRQ_EXPAN]  = pp_irq[1];
    next_irq[pil_pkg::PIL_IRQ_BOARD]  = pp_irq[2];
  end

  // Level lines; cleared sources drop one cycle later. Lines with no
  // source stay low, so a stray bit never reaches the core and the
  // handler may treat any unknown pending line as a fault.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= pil_pkg::PIL_RST_WORD;
    end else begin
      irq <= next_irq;
    end
  end

  // Fixed vectors for the core, held in flip-flops so that every
  // output of the block comes from a register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reset_vector     <= pil_pkg::PIL_RESET_VEC;
      exception_vector <= pil_pkg::PIL_EXCEPT_VEC;
    end else begin
      reset_vector     <= pil_pkg::PIL_RESET_VEC;
      exception_vector <= pil_pkg::PIL_EXCEPT_VEC;
    end
  end

  // ==========================================================
  // Read mux
  // Register map, byte offsets from the slave's own base:
  //   0x000, 0x010, 0x020  port data: filtered pin level, read only
  //   port + 0x8           interrupt enable mask, one bit per pin
  //   port + 0xC           rising-change latch; any write clears it
  //   0x030                serial data: fill count high, character low
  //   0x034                serial control: free count, enables, pending
  //   0x040, 0x050         timer status: zero flag; any write clears
  //   0x044, 0x054         timer control: zero interrupt enable
  //   0x060                request line vector, read only
  // Unlisted words read zero and answer with an error, so a bad
  // pointer in a handler shows up at once instead of reading stale
  // data from a neighbour.
  logic [31:0] rd_val;
  logic        rd_ok;

  always_comb begin
    rd_val = '0;
    rd_ok  = 1'b0;
    for (int p = 0; p < 3; p++) begin
      if (hit(paddr, pp_addr(p, pil_pkg::PIL_PP_DATA))) begin
        rd_val[PORT_W-1:0] = level[p];
        rd_ok = 1'b1;
      end
      if (hit(paddr, pp_addr(p, pil_pkg::PIL_PP_MASK))) begin
        rd_val[PORT_W-1:0] = mask[p];
        rd_ok = 1'b1;
      end
      if (hit(paddr, pp_addr(p, pil_pkg::PIL_PP_EDGE))) begin
        rd_val[PORT_W-1:0] = latch[p];
        rd_ok = 1'b1;
      end
    end
    if (hit(paddr, pil_pkg::PIL_SER_DATA)) begin
      rd_val[31:16] = rx_fill_count;
      rd_val[7:0]   = rx_char;
      rd_ok = 1'b1;
    end
    if (hit(paddr, pil_pkg::PIL_SER_CTRL)) begin
      rd_val[31:16] = tx_free_count;
      rd_val[pil_pkg::PIL_RXEN_BIT]  = rx_en;
      rd_val[pil_pkg::PIL_TXEN_BIT]  = tx_en;
      rd_val[pil_pkg::PIL_RXPND_BIT] = rx_pend;
      rd_val[pil_pkg::PIL_TXPND_BIT] = tx_pend;
      rd_ok = 1'b1;
    end
    for (int t = 0; t < 2; t++) begin
      if (hit(paddr, tmr_addr(t, pil_pkg::PIL_TMR_STAT))) begin
        rd_val[pil_pkg::PIL_ZERO_BIT] = zero_flag[t];
        rd_ok = 1'b1;
      end
      if (hit(paddr, tmr_addr(t, pil_pkg::PIL_TMR_CTRL))) begin
        rd_val[pil_pkg::PIL_ZEN_BIT] = zero_en[t];
        rd_ok = 1'b1;
      end
    end
    if (hit(paddr, pil_pkg::PIL_PEND)) begin
      rd_val = irq;
      rd_ok  = 1'b1;
    end
  end

  // Registered answer; unmapped addresses give zero and an error.
  // Data are captured in the wait state, while the request is known
  // to be steady, and held until the next access.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= pil_pkg::PIL_RST_WORD;
      pslverr <= 1'b0;
    end else if (acc & ~pready) begin
      prdata  <= pwrite ? pil_pkg::PIL_RST_WORD : rd_val;
      pslverr <= ~rd_ok;
    end else begin
      pslverr <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// ---- verification/pil_top_props.sv ----
// Purpose: Port checker for pil_top.
// Assumes: One wait state on APB. Notes: bound below.
`timescale 1ns/10ps
`default_nettype none
module pil_top_props (
  // Watched ports
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        rx_pop,
  input wire logic        tx_push,
  input wire logic [7:0]  tx_char,
  input wire logic        timer0_zero,
  input wire logic [31:0] reset_vector,
  input wire logic [31:0] exception_vector,
  input wire logic [31:0] irq
);
  // ==========================================
  // Shared clocking; a completing write
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic done_w;
  assign done_w = psel && penable && pready && pwrite;
  chk_reset_vec: assert property (reset_vector == 32'h0000_0000)
    else $error("reset vector wrong");
  chk_shared_vec: assert property (exception_vector == 32'h0000_0020)
    else $error("exception vector wrong");
  chk_unused_lines: assert property ((irq & 32'hFFFF_D6F8) == 32'h0000_0000)
    else $error("unassigned line high");
  chk_one_wait: assert property ($rose(penable) |-> !pready ##1 pready)
    else $error("wait state count wrong");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  chk_hole_err: assert property (pready && paddr == 12'h004 |-> pslverr)
    else $error("unmapped access accepted");
  chk_mask_ok: assert property (pready && paddr == 12'h008 |-> !pslverr)
    else $error("mask access refused");
  chk_latch_clear: assert property (done_w && paddr == 12'h00C |-> ##2 !irq[1])
    else $error("key line not cleared");
  chk_zero_clear: assert property (done_w && paddr == 12'h040 && !timer0_zero ##1
    !timer0_zero |=> !irq[0])
    else $error("timer line not cleared");
  chk_pop_pulse: assert property (psel && penable && pready && !pwrite &&
    paddr == 12'h030 |=> rx_pop)
    else $error("receive pop missing");
  chk_push_char: assert property (done_w && paddr == 12'h030 |=>
    tx_push && tx_char == $past(pwdata[7:0]))
    else $error("transmit push wrong");
  chk_strobe_src: assert property (rx_pop || tx_push |->
    $past(psel && penable && pready && paddr == 12'h030))
    else $error("stray buffer strobe");
endmodule
bind pil_top pil_top_props pil_top_props_i (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .rx_pop(rx_pop), .tx_push(tx_push), .tx_char(tx_char),
  .timer0_zero(timer0_zero), .reset_vector(reset_vector),
  .exception_vector(exception_vector), .irq(irq));
`default_nettype wire

// ---- verification/pil_cpu_model.sv ----
// Purpose: Core model taking the request lines.
// Assumes: Level lines. Notes: tracks next fetch address only.
`timescale 1ns/10ps
`default_nettype none
module pil_cpu_model (
  // Clock, reset and lines from the block
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [31:0] irq,
  input  wire logic [31:0] reset_vector,
  input  wire logic [31:0] exception_vector,
  // Core state seen by the bench
  output var  logic [31:0] fetch_addr
);
  // ==========================================
  // Any pending line diverts to one shared vector, so the
  // handler must sort sources out from the line vector
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fetch_addr <= 32'h0000_0000;
    end else begin
      fetch_addr <= (|irq) ? exception_vector : reset_vector;
    end
  end
endmodule
`default_nettype wire

// ---- verification/test_pil_top.sv ----
// Purpose: Self-checking bench for pil_top.
// Assumes: Pins latch within 5 edges. Notes: waits padded.
`timescale 1ns/10ps
`default_nettype none
module test_pil_top;
  // ==========================================
  // Signals
  logic        pclk = 0;
  logic        presetn = 0;
  logic        psel = 0;
  logic        penable = 0;
  logic        pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata, irq, rv, ev, fetch_addr;
  logic        pready, pslverr;
  logic [31:0] pins [3] = '{default: '0};
  logic [15:0] rxf = '0;
  logic [15:0] txf = '0;
  logic [7:0]  rxc = '0;
  logic [7:0]  txc;
  logic [1:0]  tz = '0;
  int          miscompares = 0;
  int          n_tests = 0;
  int          cyc = 0;
  always #5 pclk = ~pclk;
  pil_top pil_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .key_in(pins[0]), .expan_in(pins[1]), .board_in(pins[2]),
    .rx_fill_count(rxf), .tx_free_count(txf), .rx_char(rxc), .rx_pop(), .tx_push(),
    .tx_char(txc), .timer0_zero(tz[0]), .timer1_zero(tz[1]), .reset_vector(rv),
    .exception_vector(ev), .irq(irq));
  pil_cpu_model pil_cpu_model_i (.pclk(pclk), .presetn(presetn), .irq(irq),
    .reset_vector(rv), .exception_vector(ev), .fetch_addr(fetch_addr));
  // ==========================================
  // Bus and compare helpers; idle edge after each transfer
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic er);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] x);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, '0, q, e);
    chk(q, x);
  endtask
  task automatic pulse(input int t);
    tz[t] <= 1'b1;
    wt(1);
    tz[t] <= 1'b0;
    wt(3);
  endtask
  // ==========================================
  // Scenarios
  task automatic t_vec;
    logic [31:0] q;
    logic        e;
    chk(fetch_addr, 32'h0000_0000);
    rdc(12'h008, pil_pkg::PIL_RST_WORD);
    apb(1'b0, 12'h004, '0, q, e);
    chk({e, q[30:0]}, 32'h8000_0000);
    wr(12'h008, 32'hA5A5_5A5A);
    rdc(12'h008, 32'hA5A5_5A5A);
    wr(12'h008, '0);
    $display("t_vec done");
  endtask
  task automatic t_ports;
    int          ln [3] = '{1, 11, 13};
    logic [11:0] b;
    for (int p = 0; p < 3; p++) begin
      b = 12'(p * 16);
      wr(b + 12'h008, 32'h0000_0001);
      pins[p] <= 32'h0000_0003;
      wt(8);
      rdc(b + 12'h00C, 32'h0000_0003);
      chk(irq, 32'(1) << ln[p]);
      rdc(12'h060, 32'(1) << ln[p]);
      wr(b + 12'h00C, 32'h1234_5678);
      wt(2);
      chk(irq, 32'h0000_0000);
      rdc(b + 12'h00C, 32'h0000_0000);
      pins[p] <= 32'h0000_0004;
      wt(8);
      rdc(b + 12'h00C, 32'h0000_0004);
      chk(irq, 32'h0000_0000);
      wr(b + 12'h00C, '0);
    end
    $display("t_ports done");
  endtask
  task automatic t_serial;
    rxf <= 16'd8;
    txf <= 16'd7;
    rxc <= 8'h5A;
    wt(3);
    chk(irq, 32'h0000_0000);
    wr(12'h034, 32'h0000_0001);
    wt(3);
    chk(irq, 32'h0000_0100);
    rdc(12'h034, 32'h0007_0101);
    rdc(12'h030, 32'h0008_005A);
    rxf <= 16'd7;
    txf <= 16'd8;
    wt(3);
    chk(irq, 32'h0000_0000);
    wr(12'h034, 32'h0000_0002);
    wt(3);
    rdc(12'h034, 32'h0008_0202);
    chk(irq, 32'h0000_0100);
    wr(12'h030, 32'h0000_00C3);
    chk({24'h00_0000, txc}, 32'h0000_00C3);
    wr(12'h034, '0);
    $display("t_serial done");
  endtask
  task automatic t_timers;
    logic [11:0] b;
    for (int t = 0; t < 2; t++) begin
      b = 12'h040 + 12'(t * 16);
      wr(b + 12'h004, 32'h0000_0001);
      pulse(t);
      chk(irq, 32'(1) << (2 * t));
      chk(fetch_addr, 32'h0000_0020);
      rdc(b, 32'h0000_0001);
      wr(b, 32'hFFFF_FFFF);
      wt(2);
      chk(irq, 32'h0000_0000);
      wr(b + 12'h004, '0);
      pulse(t);
      chk(irq, 32'h0000_0000);
      rdc(b, 32'h0000_0001);
      wr(b, '0);
    end
    $display("t_timers done");
  endtask
  // ==========================================
  // Verdict, watchdog and main sequence
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      finish_test();
    end
  end
  initial begin
    wt(10);
    presetn <= 1'b1;
    wt(1);
    t_vec();
    t_ports();
    t_serial();
    t_timers();
    finish_test();
  end
endmodule
`default_nettype wire
